// >>> hw/dss_pkg.sv
// constants and types shared by the spreading transmitter and correlator
// How it works
// - transmit byte goes out bit 0 first, then ascending to bit 7.
// - an 8-bit mask marks each data bit valid (1) or invalid (0).
// - valid bit sends its data; invalid bit sends preamble for that bit time.
// - shifting goes on while valid flags remain; mask 0x0f sends four bits.
// - the 64-bit code spreads each data bit in 64-chip mode.
// - the code splits into two 32-chip codes, used singly or alternately.
// - code chips go out from code bit 0 upward.
// - code bytes sit at 0x11 (bits 7:0) through 0x18 (bits 63:56).
// - a bit decodes as zero when matches stay at or below the low limit.
// - a zero bit is the inverted code, giving zero matches when perfect.
// - a one decision uses only the high limit; a zero needs the low limit and no one.
// - a bit decodes as one when matches reach the high limit, default 0x38.
// - empty sets when the byte enters the shifter; a byte write clears it.
// - underflow sets when the next bit is due but no byte waits.
// - overflow sets when a byte is written before the previous one was taken.
`default_nettype none
package dss_pkg;
  localparam logic [7:0] DSS_OFF_STATUS = 8'h0e;
  localparam logic [7:0] DSS_OFF_TX_BYTE = 8'h0f;
  localparam logic [7:0] DSS_OFF_VALID = 8'h10;
  localparam logic [7:0] DSS_OFF_CODE_LO = 8'h11;
  localparam logic [7:0] DSS_OFF_CODE_HI = 8'h18;
  localparam logic [7:0] DSS_OFF_ZLIM = 8'h19;
  localparam logic [7:0] DSS_OFF_OLIM = 8'h1a;
  localparam logic [7:0] DSS_OFF_MODE = 8'h1b;
  localparam logic [7:0] DSS_RST_TX_BYTE = 8'h00;
  localparam logic [7:0] DSS_RST_VALID = 8'h00;
  localparam logic [63:0] DSS_RST_CODE = 64'h1e8b6a3de0e9b222;
  localparam logic [6:0] DSS_RST_ZLIM = 7'h08;
  localparam logic [6:0] DSS_RST_OLIM = 7'h38;
  localparam int DSS_ST_EMPTY = 0;
  localparam int DSS_ST_DONE = 1;
  localparam int DSS_ST_OVF = 2;
  localparam int DSS_ST_UNF = 3;
  localparam logic [6:0] DSS_CHIPS_FULL = 7'h40;
  localparam logic [6:0] DSS_CHIPS_HALF = 7'h20;
  localparam logic [5:0] DSS_HALF_BASE = 6'h20;
  typedef enum logic [1:0] {
    DSS_M64 = 2'h0,
    DSS_M32_LO = 2'h1,
    DSS_M32_HI = 2'h2,
    DSS_M32_ALT = 2'h3
  } dss_mode_t;
  localparam dss_mode_t DSS_RST_MODE = DSS_M64;
  typedef enum logic [1:0] {
    DSS_IDLE = 2'b01,
    DSS_SEND = 2'b10
  } dss_state_t;
endpackage
`default_nettype wire

// >>> hw/dss_spread_core.sv
// transmit serializer with chip spreading and receive chip correlator
`timescale 1ns/10ps
`default_nettype none
module dss_spread_core import dss_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic chip_out,
  output logic chip_valid,
  input wire logic chip_ready,
  input wire logic rx_chip,
  input wire logic rx_chip_valid,
  input wire logic rx_sync,
  output logic rx_bit,
  output logic rx_bit_valid
);
  function automatic logic [6:0] chips_per_bit(input dss_mode_t m);
    return (m == DSS_M64) ? DSS_CHIPS_FULL : DSS_CHIPS_HALF;
  endfunction
  function automatic logic code_chip(input logic [63:0] code,
      input dss_mode_t m, input logic half, input logic [6:0] idx);
    logic [5:0] base;
    base = 6'h00;
    if (m == DSS_M32_HI || (m == DSS_M32_ALT && half)) begin
      base = DSS_HALF_BASE;
    end
    return code[6'(base + idx[5:0])];
  endfunction

  logic [7:0] tx_byte_reg, tx_bit_valid_mask_reg;
  logic [63:0] spreading_code_reg;
  logic [6:0] zero_match_limit_reg, one_match_limit_reg;
  dss_mode_t mode_reg;
  logic empty_reg, done_reg, ovf_reg, unf_reg, pending_reg;
  dss_state_t state_reg;
  logic [7:0] sh_data_reg, sh_mask_reg;
  logic [6:0] cidx_reg;
  logic half_reg;
  logic buf_mem_reg [2];
  logic buf_wptr_reg, buf_rptr_reg;
  logic [1:0] buf_cnt_reg;
  logic [6:0] rx_idx_reg, rx_match_reg, last_match_reg;
  logic rx_half_reg;

  logic wr_byte, rd_status, push, last_chip, bit_end, byte_end, load;
  logic buf_in_ready, chip_in, pop, tx_chip;
  logic [7:0] rem_mask;
  logic [6:0] rx_sum;
  logic [2:0] code_sel;

  assign wr_byte = reg_wr && reg_addr == DSS_OFF_TX_BYTE;
  assign rd_status = reg_rd && reg_addr == DSS_OFF_STATUS;
  assign code_sel = 3'(reg_addr - DSS_OFF_CODE_LO);
  assign buf_in_ready = buf_cnt_reg != 2'h2;
  assign push = state_reg == DSS_SEND && buf_in_ready;
  assign last_chip = cidx_reg == 7'(chips_per_bit(mode_reg) - 7'h01);
  assign bit_end = push && last_chip;
  assign rem_mask = {1'b0, sh_mask_reg[7:1]};
  assign byte_end = bit_end && rem_mask == 8'h00;
  assign load = pending_reg && (state_reg == DSS_IDLE || byte_end);
  assign tx_chip = code_chip(spreading_code_reg, mode_reg, half_reg,
    cidx_reg);
  // zero inverts code, invalid bit sends preamble
  assign chip_in = (sh_mask_reg[0] && !sh_data_reg[0]) ? !tx_chip : tx_chip;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_byte_reg <= DSS_RST_TX_BYTE;
      tx_bit_valid_mask_reg <= DSS_RST_VALID;
      spreading_code_reg <= DSS_RST_CODE;
      zero_match_limit_reg <= DSS_RST_ZLIM;
      one_match_limit_reg <= DSS_RST_OLIM;
      mode_reg <= DSS_RST_MODE;
    end else if (reg_wr) begin
      if (reg_addr == DSS_OFF_TX_BYTE) tx_byte_reg <= reg_wdata;
      if (reg_addr == DSS_OFF_VALID) tx_bit_valid_mask_reg <= reg_wdata;
      if (reg_addr >= DSS_OFF_CODE_LO && reg_addr <= DSS_OFF_CODE_HI) begin
        spreading_code_reg[{code_sel, 3'h0} +: 8] <= reg_wdata;
      end
      if (reg_addr == DSS_OFF_ZLIM) zero_match_limit_reg <= reg_wdata[6:0];
      if (reg_addr == DSS_OFF_OLIM) one_match_limit_reg <= reg_wdata[6:0];
      if (reg_addr == DSS_OFF_MODE) mode_reg <= dss_mode_t'(reg_wdata[1:0]);
    end
  end

  // read data is registered, one cycle after reg_rd
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      if (reg_addr == DSS_OFF_STATUS) begin
        reg_rdata <= {4'h0, unf_reg, ovf_reg, done_reg, empty_reg};
      end
      if (reg_addr == DSS_OFF_TX_BYTE) reg_rdata <= tx_byte_reg;
      if (reg_addr == DSS_OFF_VALID) reg_rdata <= tx_bit_valid_mask_reg;
      if (reg_addr >= DSS_OFF_CODE_LO && reg_addr <= DSS_OFF_CODE_HI) begin
        reg_rdata <= spreading_code_reg[{code_sel, 3'h0} +: 8];
      end
      if (reg_addr == DSS_OFF_ZLIM) reg_rdata <= {1'b0, zero_match_limit_reg};
      if (reg_addr == DSS_OFF_OLIM) reg_rdata <= {1'b0, one_match_limit_reg};
      if (reg_addr == DSS_OFF_MODE) reg_rdata <= {6'h00, mode_reg};
    end
  end

  // status flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      empty_reg <= 1'b0;
      done_reg <= 1'b0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      empty_reg <= load || (empty_reg && !wr_byte);
      unf_reg <= (byte_end && !pending_reg) || (unf_reg && !rd_status);
      done_reg <= (byte_end && !pending_reg) || (done_reg && !rd_status);
      ovf_reg <= (wr_byte && pending_reg && !load) || (ovf_reg && !rd_status);
      pending_reg <= wr_byte || (pending_reg && !load);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= DSS_IDLE;
      sh_data_reg <= 8'h00;
      sh_mask_reg <= 8'h00;
      cidx_reg <= 7'h00;
      half_reg <= 1'b0;
    end else if (load) begin
      sh_data_reg <= tx_byte_reg;
      sh_mask_reg <= tx_bit_valid_mask_reg;
      cidx_reg <= 7'h00;
      if (state_reg == DSS_IDLE) half_reg <= 1'b0;
      else half_reg <= !half_reg;
      // an all-invalid byte sends nothing
      state_reg <= (tx_bit_valid_mask_reg != 8'h00) ? DSS_SEND : DSS_IDLE;
    end else if (bit_end) begin
      sh_data_reg <= {1'b0, sh_data_reg[7:1]};
      sh_mask_reg <= rem_mask;
      cidx_reg <= 7'h00;
      half_reg <= !half_reg;
      if (rem_mask == 8'h00) state_reg <= DSS_IDLE;
    end else if (push) begin
      cidx_reg <= 7'(cidx_reg + 7'h01);
    end
  end

  // two-entry chip buffer; a stalled modem holds the shifter, no chip lost
  assign pop = chip_valid && chip_ready;
  assign chip_valid = buf_cnt_reg != 2'h0;
  assign chip_out = buf_mem_reg[buf_rptr_reg];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_mem_reg[0] <= 1'b0;
      buf_mem_reg[1] <= 1'b0;
      buf_wptr_reg <= 1'b0;
      buf_rptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (push) buf_mem_reg[buf_wptr_reg] <= chip_in;
      if (push) buf_wptr_reg <= !buf_wptr_reg;
      if (pop) buf_rptr_reg <= !buf_rptr_reg;
      if (push && !pop) buf_cnt_reg <= 2'(buf_cnt_reg + 2'h1);
      if (pop && !push) buf_cnt_reg <= 2'(buf_cnt_reg - 2'h1);
    end
  end

  // correlator; counts between limits give no bit
  assign rx_sum = 7'(rx_match_reg + {6'h00, rx_chip == code_chip(
    spreading_code_reg, mode_reg, rx_half_reg, rx_idx_reg)});
  always_ff @(posedge clk) begin
    if (sys_rst || rx_sync) begin
      rx_idx_reg <= 7'h00;
      rx_match_reg <= 7'h00;
      rx_half_reg <= 1'b0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
      last_match_reg <= 7'h00;
    end else begin
      rx_bit_valid <= 1'b0;
      if (rx_chip_valid) begin
        if (rx_idx_reg == 7'(chips_per_bit(mode_reg) - 7'h01)) begin
          rx_idx_reg <= 7'h00;
          rx_match_reg <= 7'h00;
          rx_half_reg <= !rx_half_reg;
          last_match_reg <= rx_sum;
          rx_bit <= rx_sum >= one_match_limit_reg;
          rx_bit_valid <= rx_sum >= one_match_limit_reg ||
            rx_sum <= zero_match_limit_reg;
        end else begin
          rx_idx_reg <= 7'(rx_idx_reg + 7'h01);
          rx_match_reg <= rx_sum;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_lsb_first_shift: assert property (bit_end && !load |=>
    sh_data_reg == ($past(sh_data_reg) >> 1)) else $error("lsb order");
  a_preamble_chip: assert property (push && !sh_mask_reg[0] |=>
    buf_mem_reg[$past(buf_wptr_reg)] == $past(tx_chip))
    else $error("preamble chip wrong");
  a_zero_inverted: assert property (push && sh_mask_reg[0] &&
    !sh_data_reg[0] |=> buf_mem_reg[$past(buf_wptr_reg)] == !$past(tx_chip))
    else $error("zero chip");
  a_send_has_valid: assert property (state_reg == DSS_SEND |->
    sh_mask_reg != 8'h00) else $error("sending with no valid bit");
  a_chip_ascend: assert property (push && !last_chip && !load |=>
    cidx_reg == 7'($past(cidx_reg) + 7'h01)) else $error("chip order");
  a_mask_capture: assert property (load |=>
    sh_mask_reg == $past(tx_bit_valid_mask_reg)) else $error("mask");
  a_empty_set: assert property (load |=> empty_reg)
    else $error("empty not set");
  a_empty_clear: assert property (wr_byte && !load |=> !empty_reg)
    else $error("empty not cleared");
  a_underflow_set: assert property (byte_end && !pending_reg |=>
    unf_reg && state_reg == DSS_IDLE) else $error("underflow");
  a_overflow_set: assert property (wr_byte && pending_reg && !load
    |=> ovf_reg) else $error("overflow missed");
  // limits as they stood when the decision was registered
  a_rx_decide: assert property (rx_bit_valid |-> (rx_bit ?
    last_match_reg >= $past(one_match_limit_reg) :
    last_match_reg <= $past(zero_match_limit_reg)))
    else $error("rx decision");
  a_buf_hold: assert property (chip_valid && !chip_ready |=>
    chip_valid && $stable(chip_out)) else $error("chip lost");
  c_half_byte: cover property (load && tx_bit_valid_mask_reg == 8'h0f);
  c_back_to_back: cover property (byte_end && load);
  c_overflow: cover property (wr_byte && pending_reg && !load);
  c_rx_one: cover property (rx_bit_valid && rx_bit);
endmodule // dss_spread_core
`default_nettype wire

// >>> tb/dss_chip_sink.sv
// modem-side chip sink that stalls at random and records every chip taken
`timescale 1ns/10ps
`default_nettype none
module dss_chip_sink (
  input wire logic clk,
  input wire logic chip_out,
  input wire logic chip_valid,
  output logic chip_ready
);
  logic got[$];
  initial chip_ready = 1'b0;
  // stalls make the transmit buffer fill, so a lost or repeated chip shows
  always @(negedge clk) begin
    chip_ready <= ($urandom_range(3) != 0);
  end
  always @(posedge clk) begin
    if (chip_valid && chip_ready) begin
      got.push_back(chip_out);
    end
  end
endmodule // dss_chip_sink
`default_nettype wire

// >>> tb/dss_spread_core_test.sv
// self-checking bench for the spreading transmitter and correlator
`timescale 1ns/10ps
`default_nettype none
module dss_spread_core_test;
  import dss_pkg::*;
  localparam logic [7:0] MASKS [4] = '{8'ha5, 8'h0f, 8'h03, 8'h06};
  logic clk, sys_rst, reg_wr, reg_rd, rx_chip, rx_chip_valid, rx_sync;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a, d;
  logic chip_out, chip_valid, chip_ready, rx_bit, rx_bit_valid;
  logic [63:0] code;
  logic exp_q[$];
  int fail_count, compares, k, lo;
  dss_spread_core i_dss_spread_core (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_out(chip_out),
    .chip_valid(chip_valid), .chip_ready(chip_ready), .rx_chip(rx_chip),
    .rx_chip_valid(rx_chip_valid), .rx_sync(rx_sync), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid));
  dss_chip_sink i_dss_chip_sink (.clk(clk), .chip_out(chip_out),
    .chip_valid(chip_valid), .chip_ready(chip_ready));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d, compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // reference model: chips of one byte as the rules order them
  task automatic expect_byte(input logic [7:0] dt, input logic [7:0] m,
                             input int mode);
    int b, j, n;
    n = 0;
    for (b = 0; b < 8; b++) if (m[b]) n = b + 1;
    for (b = 0; b < n; b++)
      for (j = 0; j < (mode == 0 ? 64 : 32); j++)
        exp_q.push_back(code[(mode == 2 || (mode == 3 && b[0])) ? j + 32 : j]
                        ^ (m[b] & ~dt[b]));
  endtask
  task automatic send(input logic [7:0] dt, input logic [7:0] m,
                      input int mode);
    wr(DSS_OFF_VALID, m);
    wr(DSS_OFF_TX_BYTE, dt);
    expect_byte(dt, m, mode);
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 4000 && i_dss_chip_sink.got.size() < exp_q.size(); i++)
      @(posedge clk);
    // a few spare cycles so an extra chip or the end status would show
    repeat (8) @(posedge clk);
    if (i == 4000) begin
      fail_count++;
      finish_test();
    end else begin
      check(16'(i_dss_chip_sink.got.size()), 16'(exp_q.size()));
      foreach (exp_q[n])
        check({15'h0, i_dss_chip_sink.got[n]}, {15'h0, exp_q[n]});
      exp_q.delete();
      i_dss_chip_sink.got.delete();
    end
  endtask
  task automatic rx_try(input logic v, input int nerr);
    int j, mt;
    logic seen, bitv;
    seen = 1'b0;
    bitv = 1'b0;
    @(negedge clk);
    rx_sync = 1'b1;
    @(negedge clk);
    rx_sync = 1'b0;
    rx_chip_valid = 1'b1;
    for (j = 0; j < 64; j++) begin
      rx_chip = code[j] ^ ~v ^ (j < nerr);
      @(negedge clk);
    end
    rx_chip_valid = 1'b0;
    // the decision pulse stands from the edge that took the last chip,
    // so look at once, then at the next falling edges
    repeat (3) begin
      if (rx_bit_valid === 1'b1) begin
        seen = 1'b1;
        bitv = rx_bit;
      end
      @(negedge clk);
    end
    mt = v ? 64 - nerr : nerr;
    check({15'h0, seen}, {15'h0, mt >= 8'h38 || mt <= lo});
    if (mt >= 8'h38 || mt <= lo)
      check({15'h0, bitv}, {15'h0, mt >= 8'h38});
  endtask
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rx_chip = 1'b0;
    rx_chip_valid = 1'b0;
    rx_sync = 1'b0;
    code = 64'h1e8b6a3de0e9b222;
    lo = 8;
    void'($urandom(74577));
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    for (a = 8'h0e; a <= 8'h1b; a++)
      rdchk(a, a == 8'h19 ? 8'h08 : a == 8'h1a ? 8'h38 :
            (a >= 8'h11 && a <= 8'h18) ? code[(a - 8'h11) * 8 +: 8] : 8'h00);
    rdchk(8'h30, 8'h00);
    rx_try(1'b1, 0);
    rx_try(1'b1, 8);
    rx_try(1'b0, 0);
    rx_try(1'b0, 8);
    rx_try(1'b0, 9);
    rx_try(1'b1, 9);
    wr(DSS_OFF_ZLIM, 8'h7f);
    lo = 127;
    rdchk(DSS_OFF_ZLIM, 8'h7f);
    rx_try(1'b0, 20);
    code = {$urandom, $urandom};
    for (k = 0; k < 8; k++)
      wr(8'(DSS_OFF_CODE_LO + k), code[k * 8 +: 8]);
    rdchk(8'h15, code[39:32]);
    // every mode, with invalid bits inside and at the top of the mask
    for (k = 0; k < 4; k++) begin
      wr(DSS_OFF_MODE, 8'(k));
      send(8'($urandom), MASKS[k], k);
      drain();
      rdchk(DSS_OFF_STATUS, 8'h0b);
    end
    wr(DSS_OFF_MODE, 8'h00);
    rdchk(DSS_OFF_STATUS, 8'h01);
    send(8'($urandom), 8'h01, 0);
    d = 8'($urandom);
    wr(DSS_OFF_VALID, 8'h0f);
    wr(DSS_OFF_TX_BYTE, d);
    rdchk(DSS_OFF_STATUS, 8'h00);
    wr(DSS_OFF_VALID, 8'h30);
    expect_byte(d, 8'h30, 0);
    drain();
    rdchk(DSS_OFF_STATUS, 8'h0b);
    d = 8'($urandom);
    wr(DSS_OFF_VALID, 8'h01);
    repeat (3) wr(DSS_OFF_TX_BYTE, d);
    expect_byte(d, 8'h01, 0);
    expect_byte(d, 8'h01, 0);
    drain();
    rdchk(DSS_OFF_STATUS, 8'h0f);
    rdchk(DSS_OFF_STATUS, 8'h01);
    // reset in mid-run brings limit, code and status back to defaults
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rdchk(DSS_OFF_ZLIM, {1'b0, DSS_RST_ZLIM});
    rdchk(DSS_OFF_CODE_LO, DSS_RST_CODE[7:0]);
    rdchk(DSS_OFF_STATUS, 8'h00);
    finish_test();
  end
endmodule // dss_spread_core_test
`default_nettype wire
